// file: rtl/rsou_defines.svh
// named offsets, field positions and timing figures of the status unit
// assumes inclusion by bare name from any design file
`ifndef RSOU_DEFINES_SVH
`define RSOU_DEFINES_SVH

`define RSOU_CLK_HZ        20000000
`define RSOU_TICK_US       1000
`define RSOU_CYC_PER_TICK  ((`RSOU_CLK_HZ / 1000000) * `RSOU_TICK_US)
`define RSOU_MIN_PULSE_MS  25
`define RSOU_TICK_W        16
`define RSOU_PULSE_W       8

`define RSOU_ADDR_STATE    12'h000
`define RSOU_ADDR_EVENT    12'h004
`define RSOU_ADDR_FNUM     12'h008
`define RSOU_ADDR_AREA     12'h00c
`define RSOU_ADDR_CMD      12'h010
`define RSOU_ADDR_OUTS     12'h014

`define RSOU_ST_STARTED    0
`define RSOU_ST_RUNNING    1
`define RSOU_ST_PAUSED     2
`define RSOU_ST_ESTOP      3
`define RSOU_ST_GUARD      4
`define RSOU_ST_MOTORS     5
`define RSOU_ST_HOME       6
`define RSOU_ST_TEACH      7
`define RSOU_ST_HIGHPWR    8
`define RSOU_ST_AUTO       9
`define RSOU_ST_REMSRC     10
`define RSOU_ST_PROGMODE   11
`define RSOU_ST_RIO_EN     12
`define RSOU_ST_PROG_LO    16
`define RSOU_ST_PROG_HI    18

`define RSOU_EV_ERROR      0
`define RSOU_EV_CRITICAL   1
`define RSOU_EV_WARN_SET   2
`define RSOU_EV_WARN_CLR   3

`define RSOU_IN_START      0
`define RSOU_IN_SEL_LO     1
`define RSOU_IN_SEL_HI     3
`define RSOU_IN_CLEAR      7
`define RSOU_CMD_MASK      8'hf1
`define RSOU_CMD_OVERLAP   8

`endif

// file: rtl/rsou_pkg.sv
// state types of the remote status output unit
// assumes rsou_defines.svh is on the include path
`include "rsou_defines.svh"
package rsou_pkg;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } rsou_sync_bit_t;

  typedef struct packed {
    logic [`RSOU_PULSE_W-1:0] cnt;
    logic                     held;
    logic                     qual;
  } rsou_pq_t;

  typedef struct packed {
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
    logic [18:0]            ctrl;
    logic [13:0]            fnum_sw;
    logic [31:0]            area_sw;
    logic                   fault;
    logic                   crit;
    logic                   warn;
    logic                   estop_latch;
    logic [7:0]             cmd_evt;
    logic                   overlap;
    logic [`RSOU_TICK_W-1:0] tick_cnt;
    logic                   tick;
    logic [7:0]             stat;
    logic                   motor;
    logic                   home;
    logic [2:0]             prog;
    logic                   accept;
    logic                   teach;
    logic [13:0]            fnum;
    logic [14:0]            box;
    logic [14:0]            plane;
    logic                   high;
  } rsou_state_t;

endpackage

// file: rtl/rsou_sync.sv
// two-flip-flop synchroniser for a group of pin levels
// assumes pins are asynchronous to i_clk
`timescale 1ns/1ns
module rsou_sync
  import rsou_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  if (W < 1) begin : g_bad
    $error("rsou_sync: width must be positive");
  end

  logic [W-1:0] meta_ff;
  logic [W-1:0] stab_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_stab;

  always_comb begin
    nxt_meta = i_async;
    nxt_stab = meta_ff;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_ff <= '0;
      stab_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      stab_ff <= nxt_stab;
    end
  end

  assign o_sync = stab_ff;
endmodule

// file: rtl/rsou_pulse_qual.sv
// qualifies one input line: high for a minimum number of ms ticks
// assumes i_level is already synchronised and i_tick is one cycle wide
`timescale 1ns/1ns
`include "rsou_defines.svh"
module rsou_pulse_qual
  import rsou_pkg::*;
#(
  parameter int MIN_TICKS = `RSOU_MIN_PULSE_MS
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_tick,
  input  wire logic i_level,
  output logic      o_qual,
  output logic      o_held
);
  if (MIN_TICKS < 1 || MIN_TICKS >= (1 << `RSOU_PULSE_W)) begin : g_bad
    $error("rsou_pulse_qual: MIN_TICKS out of range");
  end

  localparam logic [`RSOU_PULSE_W-1:0] MIN_CNT =
    MIN_TICKS[`RSOU_PULSE_W-1:0];

  rsou_pq_t st_ff;
  rsou_pq_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.qual = 1'b0;
    if (!i_level) begin
      nxt_st.cnt  = '0;
      nxt_st.held = 1'b0;
    end else if (i_tick && !st_ff.held) begin
      // one tick of slack: the count may start mid-tick
      nxt_st.cnt = st_ff.cnt + 1'b1;
      if (nxt_st.cnt >= MIN_CNT) begin // [R19]
        nxt_st.held = 1'b1;
        nxt_st.qual = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) st_ff <= '0;
    else       st_ff <= nxt_st;
  end

  assign o_qual = st_ff.qual;
  assign o_held = st_ff.held;
endmodule

// file: rtl/rsou_top.sv
// remote status output unit: status pins toward a host, apb slave
// assumes an apb master on I_CLK and host input pins asynchronous to it
//
// Notes on behaviour
// R01: idle output 0 high after startup done while no task runs
// R02: running output 1 high while a task runs and none is paused
// R03: halted output 2 high while any task is paused
// R04: fault output 3 set on error, held until clear-fault input
// R05: emergency-halt output 4 high while emergency stop is latched
// R06: guard-open output 5 high while the safeguard is open
// R07: critical-fault output 6 on critical error; clear-fault then ignored
// R08: caution output 7 on warning; tasks keep running
// R09: motor-power output high while motors are energised
// R10: home-position output high while robot is at home
// R11: program code outputs carry function number 0..7 in binary
// R12: remote-accept high in auto with remote source, or program with rio
// R13: teach-active output high in teach mode
// R14: fault number outputs binary weighted, top weight 8192
// R15: fifteen approach-area outputs follow the check boxes
// R16: fifteen approach-plane outputs follow the check planes
// R17: high-power output high while motor power is high
// R18: host drives one input operation at a time; overlap raises fault
// R19: input pulses of at least 25 ms are detected
// R20: while faulted only the clear-fault input is acted on
// R21: input 7 clears fault and the emergency stop latch
// R22: all status outputs update together on the millisecond tick
`timescale 1ns/1ns
`include "rsou_defines.svh"
module rsou_top
  import rsou_pkg::*;
#(
  parameter int CYC_PER_TICK = `RSOU_CYC_PER_TICK,
  parameter int MIN_TICKS    = `RSOU_MIN_PULSE_MS
) (
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic [7:0]  I_REMOTE_IN,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic             O_IDLE_FLAG,
  output logic             O_TASK_RUN_FLAG,
  output logic             O_TASK_HALT_FLAG,
  output logic             O_FAULT_FLAG,
  output logic             O_EMERGENCY_HALT_FLAG,
  output logic             O_GUARD_OPEN_FLAG,
  output logic             O_CRITICAL_FAULT_FLAG,
  output logic             O_CAUTION_FLAG,
  output logic             O_MOTOR_POWER_FLAG,
  output logic             O_HOME_POSITION_FLAG,
  output logic             O_PROGRAM_CODE_BIT0,
  output logic             O_PROGRAM_CODE_BIT1,
  output logic             O_PROGRAM_CODE_BIT2,
  output logic             O_REMOTE_ACCEPT_FLAG,
  output logic             O_TEACH_ACTIVE_FLAG,
  output logic [13:0]      O_FAULT_NUMBER,
  output logic [14:0]      O_APPROACH_AREA_FLAG,
  output logic [14:0]      O_APPROACH_PLANE_FLAG,
  output logic             O_HIGH_POWER_FLAG
);
  // refused at elaboration: the tick counter cannot hold the count
  if (CYC_PER_TICK < 1 || CYC_PER_TICK >= (1 << `RSOU_TICK_W)) begin : g_bad
    $error("rsou_top: CYC_PER_TICK out of range");
  end

  localparam logic [`RSOU_TICK_W-1:0] TICK_LAST =
    `RSOU_TICK_W'(CYC_PER_TICK - 1);

  rsou_state_t st_ff;
  rsou_state_t nxt_st;

  logic [7:0] in_sync;
  logic [7:0] in_qual;
  logic [7:0] in_held;

  rsou_sync #(.W(8)) u_sync (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_async (I_REMOTE_IN),
    .o_sync  (in_sync)
  );

  // one qualifier per line; program select lines are levels, not operations
  for (genvar g = 0; g < 8; g++) begin : g_qual
    rsou_pulse_qual #(.MIN_TICKS(MIN_TICKS)) u_pq (
      .i_clk   (I_CLK),
      .i_rst   (I_SYS_RST),
      .i_tick  (st_ff.tick),
      .i_level (in_sync[g]),
      .o_qual  (in_qual[g]),
      .o_held  (in_held[g])
    );
  end

  logic        setup;
  logic        access;
  logic        ev_fault;
  logic        mapped;
  logic        live_accept;
  logic        may_take;
  logic        overlap_now;
  logic [7:0]  cmd_new;
  logic [7:0]  cmd_busy;
  logic [7:0]  cmd_take;
  logic [31:0] rd_val;
  logic [31:0] outs_img;

  always_comb begin
    setup    = I_PSEL && !I_PENABLE;
    access   = I_PSEL && I_PENABLE && st_ff.pready;
    ev_fault = access && I_PWRITE && (I_PADDR == `RSOU_ADDR_EVENT)
            && I_PWDATA[`RSOU_EV_ERROR];
    mapped   = (I_PADDR == `RSOU_ADDR_STATE) || (I_PADDR == `RSOU_ADDR_EVENT)
            || (I_PADDR == `RSOU_ADDR_FNUM)  || (I_PADDR == `RSOU_ADDR_AREA)
            || (I_PADDR == `RSOU_ADDR_CMD)   || (I_PADDR == `RSOU_ADDR_OUTS);
    live_accept = (st_ff.ctrl[`RSOU_ST_AUTO] && st_ff.ctrl[`RSOU_ST_REMSRC])
               || (st_ff.ctrl[`RSOU_ST_PROGMODE]
                   && st_ff.ctrl[`RSOU_ST_RIO_EN]); // [R12]
    // teach mode locks out every remote operation
    may_take = live_accept && !st_ff.ctrl[`RSOU_ST_TEACH];
    cmd_new  = in_qual & `RSOU_CMD_MASK;
    cmd_busy = (in_held | in_qual) & `RSOU_CMD_MASK;
    overlap_now = (cmd_new != 8'h00) && ($countones(cmd_busy) > 1); // [R18]
    cmd_take = overlap_now ? 8'h00 : cmd_new;
    outs_img = {2'h0, st_ff.high, st_ff.teach, st_ff.accept, st_ff.prog,
                st_ff.home, st_ff.motor, 6'h00, st_ff.stat, 8'h00};
    unique case (I_PADDR)
      `RSOU_ADDR_STATE: rd_val = {13'h0000, st_ff.ctrl};
      `RSOU_ADDR_FNUM:  rd_val = {18'h00000, st_ff.fnum_sw};
      `RSOU_ADDR_AREA:  rd_val = st_ff.area_sw;
      `RSOU_ADDR_CMD:   rd_val = {13'h0000,
                                  in_sync[`RSOU_IN_SEL_HI:`RSOU_IN_SEL_LO],
                                  7'h00, st_ff.overlap, st_ff.cmd_evt};
      `RSOU_ADDR_OUTS:  rd_val = outs_img;
      default:          rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;

    // apb: zero-wait answer prepared during the setup cycle
    nxt_st.pready  = setup;
    nxt_st.pslverr = setup && !mapped;
    nxt_st.prdata  = setup ? rd_val : 32'h0000_0000;

    if (access && I_PWRITE && mapped) begin
      unique case (I_PADDR)
        `RSOU_ADDR_STATE: nxt_st.ctrl    = I_PWDATA[18:0];
        `RSOU_ADDR_FNUM:  nxt_st.fnum_sw = I_PWDATA[13:0];
        `RSOU_ADDR_AREA:  nxt_st.area_sw = I_PWDATA;
        `RSOU_ADDR_CMD: begin
          nxt_st.cmd_evt = st_ff.cmd_evt & ~I_PWDATA[7:0];
          if (I_PWDATA[`RSOU_CMD_OVERLAP]) nxt_st.overlap = 1'b0;
        end
        `RSOU_ADDR_EVENT: begin
          if (I_PWDATA[`RSOU_EV_ERROR])    nxt_st.fault = 1'b1; // [R04]
          if (I_PWDATA[`RSOU_EV_CRITICAL]) nxt_st.crit  = 1'b1; // [R07]
          if (I_PWDATA[`RSOU_EV_WARN_CLR]) nxt_st.warn  = 1'b0;
          if (I_PWDATA[`RSOU_EV_WARN_SET]) nxt_st.warn  = 1'b1; // [R08]
        end
        default: ;
      endcase
    end

    // emergency latch holds after the condition goes away
    if (st_ff.ctrl[`RSOU_ST_ESTOP]) nxt_st.estop_latch = 1'b1; // [R05]

    if (overlap_now) begin
      nxt_st.fault   = 1'b1; // [R18]
      nxt_st.overlap = 1'b1;
    end else if (may_take) begin
      // clear-fault has no effect once a critical error is present
      if (cmd_take[`RSOU_IN_CLEAR] && !st_ff.crit) begin // [R07]
        // a software raise in the same cycle wins over the clear
        nxt_st.fault = ev_fault; // [R21]
        if (!st_ff.ctrl[`RSOU_ST_ESTOP]) nxt_st.estop_latch = 1'b0;
        nxt_st.cmd_evt[`RSOU_IN_CLEAR] = 1'b1;
      end
      if (!st_ff.fault) // [R20]
        nxt_st.cmd_evt = nxt_st.cmd_evt
                       | (cmd_take & ~(8'h01 << `RSOU_IN_CLEAR));
    end

    // millisecond tick
    if (st_ff.tick_cnt == TICK_LAST) begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick     = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
      nxt_st.tick     = 1'b0;
    end

    // outputs move only on the tick, all from registered state
    if (st_ff.tick) begin // [R22]
      nxt_st.stat[0] = st_ff.ctrl[`RSOU_ST_STARTED]
                    && !st_ff.ctrl[`RSOU_ST_RUNNING]; // [R01]
      nxt_st.stat[1] = st_ff.ctrl[`RSOU_ST_RUNNING]
                    && !st_ff.ctrl[`RSOU_ST_PAUSED]; // [R02]
      nxt_st.stat[2] = st_ff.ctrl[`RSOU_ST_PAUSED]; // [R03]
      nxt_st.stat[3] = st_ff.fault; // [R04]
      nxt_st.stat[4] = st_ff.estop_latch; // [R05]
      nxt_st.stat[5] = st_ff.ctrl[`RSOU_ST_GUARD]; // [R06]
      nxt_st.stat[6] = st_ff.crit; // [R07]
      nxt_st.stat[7] = st_ff.warn; // [R08]
      nxt_st.motor   = st_ff.ctrl[`RSOU_ST_MOTORS]; // [R09]
      nxt_st.home    = st_ff.ctrl[`RSOU_ST_HOME]; // [R10]
      nxt_st.prog    = st_ff.ctrl[`RSOU_ST_PROG_HI:`RSOU_ST_PROG_LO]; // [R11]
      nxt_st.accept  = live_accept; // [R12]
      nxt_st.teach   = st_ff.ctrl[`RSOU_ST_TEACH]; // [R13]
      nxt_st.fnum    = st_ff.fnum_sw; // [R14]
      nxt_st.box     = st_ff.area_sw[14:0]; // [R15]
      nxt_st.plane   = st_ff.area_sw[30:16]; // [R16]
      nxt_st.high    = st_ff.ctrl[`RSOU_ST_HIGHPWR]; // [R17]
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) st_ff <= '0;
    else           st_ff <= nxt_st;
  end

  assign O_PRDATA              = st_ff.prdata;
  assign O_PREADY              = st_ff.pready;
  assign O_PSLVERR             = st_ff.pslverr;
  assign O_IDLE_FLAG           = st_ff.stat[0];
  assign O_TASK_RUN_FLAG       = st_ff.stat[1];
  assign O_TASK_HALT_FLAG      = st_ff.stat[2];
  assign O_FAULT_FLAG          = st_ff.stat[3];
  assign O_EMERGENCY_HALT_FLAG = st_ff.stat[4];
  assign O_GUARD_OPEN_FLAG     = st_ff.stat[5];
  assign O_CRITICAL_FAULT_FLAG = st_ff.stat[6];
  assign O_CAUTION_FLAG        = st_ff.stat[7];
  assign O_MOTOR_POWER_FLAG    = st_ff.motor;
  assign O_HOME_POSITION_FLAG  = st_ff.home;
  assign O_PROGRAM_CODE_BIT0   = st_ff.prog[0];
  assign O_PROGRAM_CODE_BIT1   = st_ff.prog[1];
  assign O_PROGRAM_CODE_BIT2   = st_ff.prog[2];
  assign O_REMOTE_ACCEPT_FLAG  = st_ff.accept;
  assign O_TEACH_ACTIVE_FLAG   = st_ff.teach;
  assign O_FAULT_NUMBER        = st_ff.fnum;
  assign O_APPROACH_AREA_FLAG  = st_ff.box;
  assign O_APPROACH_PLANE_FLAG = st_ff.plane;
  assign O_HIGH_POWER_FLAG     = st_ff.high;
endmodule

// file: tb/rsou_props.sv
// port assertions for the remote status output unit
// assumes binding onto rsou_top; status moves one edge after each tick
`timescale 1ns/1ns
module rsou_props
  import rsou_pkg::*;
#(
  parameter int CYC_PER_TICK = 20000
) (
  input wire logic        I_CLK,
  input wire logic        I_SYS_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic [7:0]  I_REMOTE_IN,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic        O_IDLE_FLAG,
  input wire logic        O_TASK_RUN_FLAG,
  input wire logic        O_TASK_HALT_FLAG,
  input wire logic        O_FAULT_FLAG,
  input wire logic        O_EMERGENCY_HALT_FLAG,
  input wire logic        O_CRITICAL_FAULT_FLAG,
  input wire logic        O_CAUTION_FLAG,
  input wire logic [13:0] O_FAULT_NUMBER,
  input wire logic [14:0] O_APPROACH_AREA_FLAG
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // phase of the ms tick, restarted by reset like the design's counter
  int ph_ff;
  wire [35:0] stv = {O_IDLE_FLAG, O_TASK_RUN_FLAG, O_TASK_HALT_FLAG,
    O_FAULT_FLAG, O_EMERGENCY_HALT_FLAG, O_CRITICAL_FAULT_FLAG,
    O_CAUTION_FLAG, O_FAULT_NUMBER, O_APPROACH_AREA_FLAG};
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) ph_ff <= 0;
    else ph_ff <= (ph_ff + 1) % CYC_PER_TICK;
  end
  AST_IDLE: assert property (O_IDLE_FLAG |-> !O_TASK_RUN_FLAG)
    else $error("idle raised while a task runs");
  AST_RUN: assert property (O_TASK_RUN_FLAG |-> !O_TASK_HALT_FLAG)
    else $error("running raised while paused");
  AST_TICK: assert property ($changed(stv) |-> ph_ff == 1)
    else $error("status moved off the tick");
  AST_FAULT: assert property ($fell(O_FAULT_FLAG) |-> I_REMOTE_IN[7])
    else $error("fault cleared without clear input");
  AST_CRIT: assert property
    (O_CRITICAL_FAULT_FLAG |=> O_CRITICAL_FAULT_FLAG)
    else $error("critical fault dropped before reset");
  AST_ESTOP: assert property
    ($fell(O_EMERGENCY_HALT_FLAG) |-> I_REMOTE_IN[7])
    else $error("emergency halt cleared without clear input");
  AST_RDY_ACC: assert property (O_PREADY |-> I_PSEL && I_PENABLE)
    else $error("pready outside access phase");
  AST_RDY_FIRST: assert property
    (I_PSEL && I_PENABLE && !$past(I_PENABLE) |-> O_PREADY)
    else $error("pready missing in first access cycle");
  AST_ERR: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
    else $error("pslverr without pready or with data");
  cover property ($rose(O_FAULT_FLAG));
  cover property ($rose(O_CRITICAL_FAULT_FLAG));
  cover property ($fell(O_EMERGENCY_HALT_FLAG));
  cover property (O_PSLVERR);
endmodule

bind rsou_top rsou_props #(.CYC_PER_TICK(CYC_PER_TICK)) u_props (.*);

// file: tb/rsou_host_model.sv
// host model: drives the remote input pins as a plc would
// assumes the pins are driven low between operations, never floated
`timescale 1ns/1ns
module rsou_host_model (
  input  wire logic       i_clk,
  output logic      [7:0] o_lines
);
  initial o_lines = 8'h00;
  // one line per mask unless a test wants an overlap
  // width in cycles is the caller's; long ones meet the minimum
  task automatic pulse(input logic [7:0] mask, input int cyc);
    @(posedge i_clk);
    o_lines <= mask;
    repeat (cyc) @(posedge i_clk);
    o_lines <= 8'h00;
    repeat (cyc) @(posedge i_clk);
  endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the remote status output unit
// assumes rsou_top with the checker bound to it and the host model
`timescale 1ns/1ns
module testbench;
  localparam int CYC = 20;
  logic        clk        = 1'b0;
  logic        rst        = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] q;
  logic        e;
  wire  [7:0]  pins;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [7:0]  st;
  wire  [2:0]  pc;
  wire  [13:0] fn;
  wire  [14:0] ar;
  wire  [14:0] pl;
  wire         mot;
  wire         hom;
  wire         acc;
  wire         tch;
  wire         hip;
  int          fail_count = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  always #25 clk = ~clk;
  rsou_top #(.CYC_PER_TICK(CYC), .MIN_TICKS(3)) uut (
    .I_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .I_REMOTE_IN(pins), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_IDLE_FLAG(st[0]), .O_TASK_RUN_FLAG(st[1]),
    .O_TASK_HALT_FLAG(st[2]), .O_FAULT_FLAG(st[3]),
    .O_EMERGENCY_HALT_FLAG(st[4]), .O_GUARD_OPEN_FLAG(st[5]),
    .O_CRITICAL_FAULT_FLAG(st[6]), .O_CAUTION_FLAG(st[7]),
    .O_MOTOR_POWER_FLAG(mot), .O_HOME_POSITION_FLAG(hom),
    .O_PROGRAM_CODE_BIT0(pc[0]), .O_PROGRAM_CODE_BIT1(pc[1]),
    .O_PROGRAM_CODE_BIT2(pc[2]), .O_REMOTE_ACCEPT_FLAG(acc),
    .O_TEACH_ACTIVE_FLAG(tch), .O_FAULT_NUMBER(fn),
    .O_APPROACH_AREA_FLAG(ar), .O_APPROACH_PLANE_FLAG(pl),
    .O_HIGH_POWER_FLAG(hip));
  rsou_host_model host (.i_clk(clk), .o_lines(pins));
  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, g);
    n_tests++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  // one transfer; idle cycle first so no signal is set twice per step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) fail_count++;
  endtask
  task automatic tk(input int n);
    repeat (n * CYC) @(posedge clk);
  endtask
  task automatic t_regs();
    apb(1'b0, 12'h000, 32'h0);
    chk("state_reset", 32'h0, q);
    apb(1'b0, 12'h024, 32'h0);
    chk("unmapped_err", 32'h1, e);
    chk("unmapped_data", 32'h0, q);
    apb(1'b1, 12'h014, 32'hffffffff);
    apb(1'b0, 12'h014, 32'h0);
    chk("outs_readonly", 32'h0, q);
  endtask
  task automatic t_prog();
    for (int p = 0; p < 8; p++) begin
      apb(1'b1, 12'h000, (p << 16) | (p << 4) | 1);
      tk(2);
      chk("prog_code", p, pc);
      chk("guard_motor_home", p, {hom, mot, st[5]});
      chk("idle", 32'h1, st[0]);
    end
  endtask
  task automatic t_task();
    logic [31:0] sv [4] = '{32'h003, 32'h007, 32'h005, 32'h181};
    logic [4:0]  ex [4] = '{5'h02, 5'h04, 5'h05, 5'h19};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, sv[i]);
      tk(2);
      chk("task", ex[i], {hip, tch, st[2:0]});
    end
    apb(1'b1, 12'h000, 32'h003);
    apb(1'b1, 12'h004, 32'h4);
    tk(2);
    chk("caution", 32'h1, st[7]);
    chk("run_with_caution", 32'h1, st[1]);
    apb(1'b1, 12'h004, 32'h8);
    tk(2);
    chk("caution_clear", 32'h0, st[7]);
  endtask
  task automatic t_num();
    apb(1'b1, 12'h008, 32'h2001);
    apb(1'b1, 12'h00c, 32'h40017ffe);
    tk(2);
    chk("fault_number", 32'h2001, fn);
    chk("area", 32'h7ffe, ar);
    chk("plane", 32'h4001, pl);
    apb(1'b0, 12'h014, 32'h0);
    chk("outs", 32'h200, q);
  endtask
  task automatic t_accept();
    logic [31:0] sv [5] = '{32'h601, 32'h201, 32'h1801, 32'h1001, 32'h401};
    logic [4:0]  ex = 5'b00101;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'h000, sv[i]);
      tk(2);
      chk("remote_accept", ex[i], acc);
    end
  endtask
  task automatic t_fault();
    apb(1'b1, 12'h000, 32'h609);
    tk(2);
    chk("estop", 32'h1, st[4]);
    apb(1'b1, 12'h000, 32'h601);
    tk(2);
    chk("estop_latched", 32'h1, st[4]);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b1, 12'h010, 32'hffffffff);
    host.pulse(8'h01, 6 * CYC);
    apb(1'b0, 12'h010, 32'h0);
    chk("start_blocked", 32'h0, q[0]);
    chk("fault_held", 32'h1, st[3]);
    host.pulse(8'h80, 6 * CYC);
    chk("fault_cleared", 32'h0, st[3]);
    chk("estop_cleared", 32'h0, st[4]);
    apb(1'b1, 12'h010, 32'hffffffff);
    host.pulse(8'h01, CYC);
    apb(1'b0, 12'h010, 32'h0);
    chk("short_pulse", 32'h0, q[0]);
    host.pulse(8'h01, 6 * CYC);
    apb(1'b0, 12'h010, 32'h0);
    chk("long_pulse", 32'h1, q[0]);
  endtask
  task automatic t_overlap();
    apb(1'b1, 12'h010, 32'hffffffff);
    host.pulse(8'h30, 6 * CYC);
    apb(1'b0, 12'h010, 32'h0);
    chk("overlap_bit", 32'h1, q[8]);
    chk("overlap_no_op", 32'h0, q[5:4]);
    chk("overlap_fault", 32'h1, st[3]);
    host.pulse(8'h80, 6 * CYC);
    chk("overlap_cleared", 32'h0, st[3]);
    // teach mode locks out remote operations
    apb(1'b1, 12'h000, 32'h681);
    apb(1'b1, 12'h010, 32'hffffffff);
    host.pulse(8'h01, 6 * CYC);
    apb(1'b0, 12'h010, 32'h0);
    chk("teach_lockout", 32'h0, q[0]);
    apb(1'b1, 12'h000, 32'h601);
  endtask
  task automatic t_crit();
    apb(1'b1, 12'h004, 32'h2);
    tk(2);
    chk("critical", 32'h1, st[6]);
    host.pulse(8'h80, 6 * CYC);
    chk("critical_held", 32'h1, st[6]);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tk(2);
    chk("critical_restart", 32'h0, st[6]);
  endtask
  // ceiling well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_prog();
    t_task();
    t_num();
    t_accept();
    t_fault();
    t_overlap();
    t_crit();
    print_verdict();
  end
endmodule
